// ==== hdl/oledcd_params.svh ====
// Constants of the OLED command decoder: bus offsets, opcodes, reset values.
// Assumes it is included by bare name from the core and the bench.
`ifndef OLEDCD_PARAMS_SVH
`define OLEDCD_PARAMS_SVH

`define OLEDCD_ADDR_CMD      8'h00
`define OLEDCD_ADDR_DATA     8'h04
`define OLEDCD_ADDR_STATUS   8'h08
`define OLEDCD_ADDR_WIN      8'h0c
`define OLEDCD_ADDR_LINE     8'h10
`define OLEDCD_ADDR_MODE     8'h14

`define OLEDCD_OP_GRAY_EN    8'h00
`define OLEDCD_OP_COL_WIN    8'h15
`define OLEDCD_OP_RAM_WR     8'h5c
`define OLEDCD_OP_RAM_RD     8'h5d
`define OLEDCD_OP_ROW_WIN    8'h75
`define OLEDCD_OP_REMAP      8'ha0
`define OLEDCD_OP_START_LINE 8'ha1
`define OLEDCD_OP_OFFSET     8'ha2
`define OLEDCD_OP_MODE_OFF   8'ha4
`define OLEDCD_OP_MODE_ON    8'ha5
`define OLEDCD_OP_MODE_NORM  8'ha6
`define OLEDCD_OP_MODE_INV   8'ha7
`define OLEDCD_OP_PART_ON    8'ha8
`define OLEDCD_OP_PART_OFF   8'ha9
`define OLEDCD_OP_FUNC_SEL   8'hab
`define OLEDCD_OP_SLEEP_ON   8'hae
`define OLEDCD_OP_SLEEP_OFF  8'haf
`define OLEDCD_OP_PHASE      8'hb1

`define OLEDCD_COL_MAX       7'h77
`define OLEDCD_ROW_MAX       7'h7f
`define OLEDCD_COL_END_RST   7'h77
`define OLEDCD_ROW_END_RST   7'h7f
`define OLEDCD_PH1_RST       5'h09
`define OLEDCD_PH2_RST       4'h7
`define OLEDCD_PH1_MIN_CODE  4'h2
`define OLEDCD_PH2_MIN_CODE  4'h3

`define OLEDCD_DMODE_OFF     2'h0
`define OLEDCD_DMODE_ON      2'h1
`define OLEDCD_DMODE_NORM    2'h2
`define OLEDCD_DMODE_INV     2'h3

`endif

// ==== hdl/oledcd_pkg.sv ====
// Types shared by the OLED command decoder.
// Assumes the constants header sits beside it.
package oledcd_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_PARAM = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_READ  = 4'b1000
	} oledcd_state_t;

	typedef struct packed {
		oledcd_state_t state;
		logic [7:0]    opcode;
		logic [1:0]    pcnt;
		logic [7:0]    paramA;
		logic [6:0]    colStart;
		logic [6:0]    colEnd;
		logic [6:0]    rowStart;
		logic [6:0]    rowEnd;
		logic [6:0]    curCol;
		logic [6:0]    curRow;
		logic          vertInc;
		logic          colRemap;
		logic          nibRemap;
		logic          comReverse;
		logic          comSplit;
		logic          dualCom;
		logic [6:0]    startLine;
		logic [6:0]    dispOffset;
		logic [1:0]    dispMode;
		logic          partialOn;
		logic [6:0]    partStart;
		logic [6:0]    partEnd;
		logic          internalVdd;
		logic          sleep;
		logic [4:0]    phase1Clks;
		logic [3:0]    phase2Clks;
		logic          grayEnable;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
	} oledcd_regs_t;

endpackage

// ==== hdl/oledcd_core.sv ====
// Command decoder of a gray-level OLED controller with 120 column and 128 row addresses, with an APB slave.
// Assumes an APB master on mclk; bytes reach it as APB writes to the
// command and data offsets, and RAM bytes leave it as APB data reads.
`timescale 1ns/1ns
`include "oledcd_params.svh"

module oledcd_core
	import oledcd_pkg::*;
#(
	parameter int RAM_DEPTH = 16384
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic        hwResetLow,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [6:0]  colStart,
	output logic      [6:0]  colEnd,
	output logic      [6:0]  rowStart,
	output logic      [6:0]  rowEnd,
	output logic             vertInc,
	output logic             colRemap,
	output logic             nibRemap,
	output logic             comReverse,
	output logic             comSplit,
	output logic             dualCom,
	output logic      [6:0]  startLine,
	output logic      [6:0]  dispOffset,
	output logic      [1:0]  dispMode,
	output logic             partialOn,
	output logic      [6:0]  partStart,
	output logic      [6:0]  partEnd,
	output logic             internalVdd,
	output logic             sleep,
	output logic      [4:0]  phase1Clks,
	output logic      [3:0]  phase2Clks,
	output logic             grayEnable
);

	oledcd_regs_t q;
	oledcd_regs_t next_q;
	oledcd_regs_t rstVal;

	logic [7:0]  ram [0:RAM_DEPTH-1];
	logic [13:0] ramAddr;
	logic [7:0]  ramRd;
	logic        rst;
	logic        setupCyc;
	logic        apbAcc;
	logic        cmdWr;
	logic        datWr;
	logic        datRd;
	logic        ramWe;
	logic        mapped;
	logic [31:0] readMux;

	// Number of parameter bytes that follow each opcode.
	function automatic logic [1:0] paramCount(input logic [7:0] op);
		logic [1:0] n;
		n = 2'd0;
		case (op)
			`OLEDCD_OP_COL_WIN, `OLEDCD_OP_ROW_WIN,
			`OLEDCD_OP_REMAP, `OLEDCD_OP_PART_ON: n = 2'd2;
			`OLEDCD_OP_START_LINE, `OLEDCD_OP_OFFSET,
			`OLEDCD_OP_FUNC_SEL, `OLEDCD_OP_PHASE: n = 2'd1;
			default: n = 2'd0;
		endcase
		return n;
	endfunction

	// Next RAM position inside the window; wraps to the window start.
	function automatic logic [13:0] advance(input oledcd_regs_t r);
		logic [6:0] c;
		logic [6:0] w;
		c = r.curCol;
		w = r.curRow;
		if (!r.vertInc) begin
			if (c == r.colEnd) begin
				c = r.colStart;
				w = (w == r.rowEnd) ? r.rowStart : w + 7'd1;
			end else begin
				c = c + 7'd1;
			end
		end else begin
			if (w == r.rowEnd) begin
				w = r.rowStart;
				c = (c == r.colEnd) ? r.colStart : c + 7'd1;
			end else begin
				w = w + 7'd1;
			end
		end
		return {w, c};
	endfunction

	assign rst      = srst | ~hwResetLow;
	assign setupCyc = psel & penable & ~q.pready & ce;
	assign apbAcc   = psel & penable & q.pready & ce;
	assign cmdWr    = apbAcc & pwrite & pstrb[0]
		& (paddr == `OLEDCD_ADDR_CMD);
	assign datWr    = apbAcc & pwrite & pstrb[0]
		& (paddr == `OLEDCD_ADDR_DATA);
	assign datRd    = apbAcc & ~pwrite & (paddr == `OLEDCD_ADDR_DATA);
	assign ramAddr  = {q.curRow, q.curCol};
	assign ramRd    = ram[ramAddr];
	assign ramWe    = datWr & (q.state == ST_WRITE) & ~rst;

	assign mapped = (paddr == `OLEDCD_ADDR_CMD)
		| (paddr == `OLEDCD_ADDR_DATA)
		| (paddr == `OLEDCD_ADDR_STATUS)
		| (paddr == `OLEDCD_ADDR_WIN)
		| (paddr == `OLEDCD_ADDR_LINE)
		| (paddr == `OLEDCD_ADDR_MODE);

	always_comb begin
		readMux = 32'h0;
		case (paddr)
			`OLEDCD_ADDR_DATA: begin
				if (q.state == ST_READ) begin
					readMux = {24'h0, ramRd};
				end
			end
			`OLEDCD_ADDR_STATUS: readMux = {4'h0, q.state, q.pcnt,
				q.opcode, q.curRow, q.curCol};
			`OLEDCD_ADDR_WIN: readMux = {1'b0, q.rowEnd, 1'b0, q.rowStart,
				1'b0, q.colEnd, 1'b0, q.colStart};
			`OLEDCD_ADDR_LINE: readMux = {1'b0, q.partEnd, 1'b0,
				q.partStart, 1'b0, q.dispOffset, 1'b0, q.startLine};
			`OLEDCD_ADDR_MODE: readMux = {12'h0, q.phase2Clks,
				q.phase1Clks, q.sleep, q.internalVdd, q.partialOn,
				q.dispMode, q.dualCom, q.comSplit, q.comReverse,
				q.nibRemap, q.colRemap, q.vertInc};
			default: readMux = 32'h0;
		endcase
	end

	always_comb begin
		rstVal             = '0;
		rstVal.state       = ST_IDLE;
		rstVal.colEnd      = `OLEDCD_COL_END_RST;
		rstVal.rowEnd      = `OLEDCD_ROW_END_RST;
		rstVal.dispMode    = `OLEDCD_DMODE_NORM;
		rstVal.internalVdd = 1'b1;
		rstVal.sleep       = 1'b1;
		rstVal.phase1Clks  = `OLEDCD_PH1_RST;
		rstVal.phase2Clks  = `OLEDCD_PH2_RST;
	end

	always_comb begin
		next_q = q;
		next_q.grayEnable = 1'b0;
		// The answer is registered, so every transfer has one wait state.
		next_q.pready = setupCyc;
		if (setupCyc) begin
			next_q.pslverr = ~mapped;
			next_q.prdata  = readMux;
		end
		if (cmdWr) begin
			// Any command byte drops a pending command or session.
			next_q.opcode = pwdata[7:0];
			next_q.pcnt   = 2'd0;
			next_q.state  = ST_IDLE;
			if (paramCount(pwdata[7:0]) != 2'd0) begin
				next_q.state = ST_PARAM;
			end
			case (pwdata[7:0])
				`OLEDCD_OP_GRAY_EN: next_q.grayEnable = 1'b1;
				`OLEDCD_OP_RAM_WR: begin
					next_q.state  = ST_WRITE;
					next_q.curCol = q.colStart;
					next_q.curRow = q.rowStart;
				end
				`OLEDCD_OP_RAM_RD: begin
					next_q.state  = ST_READ;
					next_q.curCol = q.colStart;
					next_q.curRow = q.rowStart;
				end
				`OLEDCD_OP_MODE_OFF, `OLEDCD_OP_MODE_ON,
				`OLEDCD_OP_MODE_NORM, `OLEDCD_OP_MODE_INV:
					next_q.dispMode = pwdata[1:0];
				`OLEDCD_OP_PART_OFF: next_q.partialOn = 1'b0;
				`OLEDCD_OP_SLEEP_ON: next_q.sleep = 1'b1;
				`OLEDCD_OP_SLEEP_OFF: next_q.sleep = 1'b0;
				default: ;
			endcase
		end else if (datWr) begin
			unique case (q.state)
				ST_PARAM: begin
					if (q.pcnt != paramCount(q.opcode) - 2'd1) begin
						next_q.paramA = pwdata[7:0];
						next_q.pcnt   = q.pcnt + 2'd1;
					end else begin
						next_q.state = ST_IDLE;
						case (q.opcode)
							`OLEDCD_OP_COL_WIN: begin
								// Out-of-range windows are dropped whole.
								if (q.paramA[6:0] <= `OLEDCD_COL_MAX
									&& pwdata[6:0] <= `OLEDCD_COL_MAX) begin
									next_q.colStart = q.paramA[6:0];
									next_q.colEnd   = pwdata[6:0];
								end
							end
							`OLEDCD_OP_ROW_WIN: begin
								next_q.rowStart = q.paramA[6:0];
								next_q.rowEnd   = pwdata[6:0];
							end
							`OLEDCD_OP_REMAP: begin
								next_q.vertInc    = q.paramA[0];
								next_q.colRemap   = q.paramA[1];
								next_q.nibRemap   = q.paramA[2];
								next_q.comReverse = q.paramA[4];
								next_q.comSplit   = q.paramA[5];
								next_q.dualCom    = pwdata[4];
							end
							`OLEDCD_OP_START_LINE:
								next_q.startLine = pwdata[6:0];
							`OLEDCD_OP_OFFSET:
								next_q.dispOffset = pwdata[6:0];
							`OLEDCD_OP_PART_ON: begin
								next_q.partialOn = 1'b1;
								next_q.partStart = q.paramA[6:0];
								next_q.partEnd   = pwdata[6:0];
							end
							`OLEDCD_OP_FUNC_SEL:
								next_q.internalVdd = pwdata[0];
							`OLEDCD_OP_PHASE: begin
								// Invalid codes leave the old length.
								if (pwdata[3:0] >= `OLEDCD_PH1_MIN_CODE) begin
									next_q.phase1Clks = {pwdata[3:0], 1'b1};
								end
								if (pwdata[7:4] >= `OLEDCD_PH2_MIN_CODE) begin
									next_q.phase2Clks = pwdata[7:4];
								end
							end
							default: ;
						endcase
					end
				end
				ST_WRITE: {next_q.curRow, next_q.curCol} = advance(q);
				ST_IDLE: ;
				ST_READ: ;
			endcase
		end else if (datRd && q.state == ST_READ) begin
			{next_q.curRow, next_q.curCol} = advance(q);
		end
	end

	// Reset wins over a low clock enable so a held reset always takes.
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= rstVal;
		end else if (ce) begin
			q <= next_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (ramWe) begin
			ram[ramAddr] <= pwdata[7:0];
		end
	end

	assign prdata      = q.prdata;
	assign pready      = q.pready;
	assign pslverr     = q.pslverr;
	assign colStart    = q.colStart;
	assign colEnd      = q.colEnd;
	assign rowStart    = q.rowStart;
	assign rowEnd      = q.rowEnd;
	assign vertInc     = q.vertInc;
	assign colRemap    = q.colRemap;
	assign nibRemap    = q.nibRemap;
	assign comReverse  = q.comReverse;
	assign comSplit    = q.comSplit;
	assign dualCom     = q.dualCom;
	assign startLine   = q.startLine;
	assign dispOffset  = q.dispOffset;
	assign dispMode    = q.dispMode;
	assign partialOn   = q.partialOn;
	assign partStart   = q.partStart;
	assign partEnd     = q.partEnd;
	assign internalVdd = q.internalVdd;
	assign sleep       = q.sleep;
	assign phase1Clks  = q.phase1Clks;
	assign phase2Clks  = q.phase2Clks;
	assign grayEnable  = q.grayEnable;

	reset_values_a: assert property (@(posedge mclk)
		rst |=> (colStart == 7'h0 && colEnd == `OLEDCD_COL_END_RST
			&& rowEnd == `OLEDCD_ROW_END_RST && startLine == 7'h0
			&& dispMode == `OLEDCD_DMODE_NORM && internalVdd
			&& phase1Clks == `OLEDCD_PH1_RST
			&& phase2Clks == `OLEDCD_PH2_RST && !partialOn))
		else $error("settings not at reset values after reset");

	gray_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdWr && pwdata[7:0] == `OLEDCD_OP_GRAY_EN)
			|=> grayEnable ##1 (!grayEnable || $past(cmdWr)))
		else $error("gray table enable not a single pulse");

	col_window_a: assert property (@(posedge mclk) disable iff (rst)
		(datWr && q.state == ST_PARAM && q.opcode == `OLEDCD_OP_COL_WIN
			&& q.pcnt == 2'd1 && q.paramA[6:0] <= `OLEDCD_COL_MAX
			&& pwdata[6:0] <= `OLEDCD_COL_MAX)
			|=> colEnd == $past(pwdata[6:0])
				&& colStart == $past(q.paramA[6:0]))
		else $error("column window not taken from parameters");

	ram_advance_a: assert property (@(posedge mclk) disable iff (rst)
		(ramWe && !vertInc && q.curCol != colEnd)
			|=> q.curCol == $past(q.curCol) + 7'd1
				&& q.curRow == $past(q.curRow))
		else $error("RAM write did not advance the column");

	ram_read_a: assert property (@(posedge mclk) disable iff (rst)
		(setupCyc && !pwrite && paddr == `OLEDCD_ADDR_DATA
			&& q.state == ST_READ)
			|=> pready && prdata[7:0] == $past(ramRd))
		else $error("RAM read returned the wrong byte");

	start_line_a: assert property (@(posedge mclk) disable iff (rst)
		(datWr && q.state == ST_PARAM
			&& q.opcode == `OLEDCD_OP_START_LINE)
			|=> startLine == $past(pwdata[6:0]) ##1 q.state != ST_PARAM
				|| $past(cmdWr))
		else $error("start line not updated");

	disp_mode_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdWr && pwdata[7:0] == `OLEDCD_OP_MODE_INV)
			|=> dispMode == `OLEDCD_DMODE_INV)
		else $error("inverse display not selected");

	partial_exit_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdWr && pwdata[7:0] == `OLEDCD_OP_PART_OFF) |=> !partialOn)
		else $error("partial display still on");

	sleep_ctl_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdWr && pwdata[7:1] == `OLEDCD_OP_SLEEP_ON >> 1)
			|=> sleep == !$past(pwdata[0]))
		else $error("sleep state wrong after sleep command");

	phase_len_a: assert property (@(posedge mclk) disable iff (rst)
		(datWr && q.state == ST_PARAM && q.opcode == `OLEDCD_OP_PHASE
			&& pwdata[3:0] >= `OLEDCD_PH1_MIN_CODE)
			|=> phase1Clks == {$past(pwdata[3:0]), 1'b1})
		else $error("phase 1 length not twice code plus one");

	cmd_abort_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdWr && q.state != ST_IDLE
			&& paramCount(pwdata[7:0]) == 2'd0
			&& pwdata[7:1] != 7'h2e)
			|=> q.state == ST_IDLE && q.pcnt == 2'd0)
		else $error("pending command not abandoned");

endmodule // oledcd_core

// ==== testbench/oledcd_host.sv ====
// Host model that drives single APB transfers into the command decoder.
// Assumes the bench top provides errors and finish_test for a hung wait.
`timescale 1ns/1ns

module oledcd_host (
	input  wire logic        mclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'h1;
	end

	// Released address and data are inverted, so a slave that samples
	// them outside a transfer never sees a convenient stale copy.
	task automatic xfer(input logic wr, input logic [7:0] addr,
		input logic [7:0] wdata, output logic [31:0] rdata,
		output logic err);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h000000, wdata};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			test_oled_command_decoder.errors++;
			test_oled_command_decoder.finish_test();
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~addr;
		pwdata <= ~pwdata;
	endtask
endmodule // oledcd_host

// ==== testbench/test_oled_command_decoder.sv ====
// Self-checking bench for the OLED command decoder core.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ns
`include "oledcd_params.svh"

module test_oled_command_decoder
	import oledcd_pkg::*;
;
	logic        mclk, srst, ce, hwResetLow, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pstrb;
	logic        pready, pslverr, vertInc, colRemap, nibRemap, comReverse;
	logic        comSplit, dualCom, partialOn, internalVdd, sleep, e;
	logic        grayEnable;
	logic [6:0]  colStart, colEnd, rowStart, rowEnd, startLine, dispOffset;
	logic [6:0]  partStart, partEnd;
	logic [1:0]  dispMode;
	logic [4:0]  phase1Clks, e1;
	logic [3:0]  phase2Clks, e2;
	logic [7:0]  phv [5] = '{8'h32, 8'hff, 8'h21, 8'h10, 8'h44};
	int          errors, check_count, grayCount;

	oledcd_core oledcd_core_inst (.mclk, .srst, .ce, .hwResetLow, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .colStart, .colEnd, .rowStart, .rowEnd, .vertInc,
		.colRemap, .nibRemap, .comReverse, .comSplit, .dualCom, .startLine,
		.dispOffset, .dispMode, .partialOn, .partStart, .partEnd,
		.internalVdd, .sleep, .phase1Clks, .phase2Clks, .grayEnable);

	oledcd_host oledcd_host_inst (.mclk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (grayEnable === 1'b1)
			grayCount++;
	end

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] d);
		logic [31:0] rr;
		logic        ee;
		oledcd_host_inst.xfer(1'b1, addr, d, rr, ee);
	endtask

	task automatic cmd(input logic [7:0] op, input int n,
		input logic [7:0] a, input logic [7:0] b);
		wr(`OLEDCD_ADDR_CMD, op);
		if (n > 0)
			wr(`OLEDCD_ADDR_DATA, a);
		if (n > 1)
			wr(`OLEDCD_ADDR_DATA, b);
		@(negedge mclk);
	endtask

	task automatic checkReset();
		checkVal({colStart, colEnd, rowStart, rowEnd},
			{7'h00, 7'h77, 7'h00, 7'h7f});
		checkVal({vertInc, colRemap, nibRemap, comReverse, comSplit, dualCom,
			startLine, dispOffset, dispMode}, 22'h2);
		checkVal({partialOn, internalVdd, sleep, phase1Clks, phase2Clks},
			{3'b011, 5'h09, 4'h7});
		$display("test finished");
	endtask

	initial begin
		srst = 1'b1;
		hwResetLow = 1'b1;
		ce = 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		checkReset();
		// A 2x2 window with five bytes makes the fifth wrap onto the first.
		cmd(`OLEDCD_OP_COL_WIN, 2, 8'h00, 8'h01);
		cmd(`OLEDCD_OP_ROW_WIN, 2, 8'h00, 8'h01);
		cmd(`OLEDCD_OP_RAM_WR, 0, 8'h00, 8'h00);
		for (int i = 0; i < 5; i++)
			wr(`OLEDCD_ADDR_DATA, 8'ha0 + i[7:0]);
		cmd(`OLEDCD_OP_RAM_RD, 0, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			oledcd_host_inst.xfer(1'b0, `OLEDCD_ADDR_DATA, 8'h00, r, e);
			checkVal(r[7:0], (i == 0) ? 8'ha4 : 8'ha0 + i[7:0]);
		end
		cmd(`OLEDCD_OP_MODE_NORM, 0, 8'h00, 8'h00);
		oledcd_host_inst.xfer(1'b0, `OLEDCD_ADDR_DATA, 8'h00, r, e);
		checkVal(r, 32'h0);
		oledcd_host_inst.xfer(1'b0, 8'h20, 8'h00, r, e);
		checkVal(e, 1'b1);
		$display("test finished");
		cmd(`OLEDCD_OP_COL_WIN, 2, 8'h03, 8'h64);
		cmd(`OLEDCD_OP_COL_WIN, 2, 8'h05, 8'h78);
		cmd(`OLEDCD_OP_ROW_WIN, 2, 8'h02, 8'h7e);
		checkVal({colStart, colEnd, rowStart, rowEnd},
			{7'h03, 7'h64, 7'h02, 7'h7e});
		wr(`OLEDCD_ADDR_CMD, `OLEDCD_OP_COL_WIN);
		wr(`OLEDCD_ADDR_DATA, 8'h09);
		cmd(`OLEDCD_OP_MODE_NORM, 0, 8'h00, 8'h00);
		wr(`OLEDCD_ADDR_DATA, 8'h0a);
		@(negedge mclk);
		checkVal({colStart, colEnd}, {7'h03, 7'h64});
		cmd(`OLEDCD_OP_REMAP, 2, 8'h17, 8'h11);
		checkVal({vertInc, colRemap, nibRemap, comReverse, comSplit, dualCom},
			6'b111101);
		cmd(`OLEDCD_OP_REMAP, 2, 8'h20, 8'h00);
		checkVal({vertInc, colRemap, nibRemap, comReverse, comSplit, dualCom},
			6'b000010);
		cmd(`OLEDCD_OP_START_LINE, 1, 8'h7f, 8'h00);
		cmd(`OLEDCD_OP_OFFSET, 1, 8'h40, 8'h00);
		checkVal({startLine, dispOffset}, {7'h7f, 7'h40});
		for (int i = 0; i < 4; i++) begin
			cmd(8'ha4 + i[7:0], 0, 8'h00, 8'h00);
			checkVal(dispMode, i[1:0]);
		end
		cmd(`OLEDCD_OP_PART_ON, 2, 8'h0a, 8'h14);
		checkVal({partialOn, partStart, partEnd}, {1'b1, 7'h0a, 7'h14});
		cmd(`OLEDCD_OP_PART_OFF, 0, 8'h00, 8'h00);
		checkVal(partialOn, 1'b0);
		cmd(`OLEDCD_OP_FUNC_SEL, 1, 8'h00, 8'h00);
		checkVal(internalVdd, 1'b0);
		cmd(`OLEDCD_OP_SLEEP_OFF, 0, 8'h00, 8'h00);
		checkVal(sleep, 1'b0);
		cmd(`OLEDCD_OP_SLEEP_ON, 0, 8'h00, 8'h00);
		checkVal(sleep, 1'b1);
		e1 = 5'h09;
		e2 = 4'h7;
		foreach (phv[i]) begin
			cmd(`OLEDCD_OP_PHASE, 1, phv[i], 8'h00);
			if (phv[i][3:0] >= 4'h2)
				e1 = {phv[i][3:0], 1'b1};
			if (phv[i][7:4] >= 4'h3)
				e2 = phv[i][7:4];
			checkVal({phase1Clks, phase2Clks}, {e1, e2});
		end
		cmd(`OLEDCD_OP_GRAY_EN, 0, 8'h00, 8'h00);
		repeat (2) @(negedge mclk);
		checkVal(grayCount, 1);
		$display("test finished");
		// A reset in mid-command must also drop the pending parameter count.
		wr(`OLEDCD_ADDR_CMD, `OLEDCD_OP_COL_WIN);
		wr(`OLEDCD_ADDR_DATA, 8'h05);
		@(posedge mclk);
		hwResetLow <= 1'b0;
		@(posedge mclk);
		hwResetLow <= 1'b1;
		wr(`OLEDCD_ADDR_DATA, 8'h07);
		@(negedge mclk);
		checkReset();
		finish_test();
	end
endmodule // test_oled_command_decoder
